// *** logic/bcfm_pkg.sv ***
// Purpose: Shared constants and types for the coupler fault manager
// Assumes: 100 MHz clock, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package bcfm_pkg;
   // Register byte offsets
   localparam logic [7:0] BCFM_CTRL_OFS = 8'h00;
   localparam logic [7:0] BCFM_STAT_OFS = 8'h04;
   localparam logic [7:0] BCFM_CNT_OFS = 8'h08;
   // Control bit positions
   localparam int BCFM_CTRL_TEST_BIT = 0;
   localparam int BCFM_CTRL_CLR_BIT = 1;
   // Status codes
   localparam logic [1:0] BCFM_ST_FAULT = 2'h0;
   localparam logic [1:0] BCFM_ST_ONE = 2'h1;
   localparam logic [1:0] BCFM_ST_TWO = 2'h2;
   localparam logic [1:0] BCFM_ST_NONE = 2'h3;
   // Channel changes that lead to coupler fault
   localparam logic [1:0] BCFM_FAULT_LIMIT = 2'h3;
   // Wraparound slack in bit times, and bit period
   localparam int BCFM_WRAP_BITS = 3;
   localparam int BCFM_BIT_NS = 500;
   localparam int BCFM_CLK_NS = 10;
   localparam int BCFM_WRAP_CYC = (BCFM_WRAP_BITS * BCFM_BIT_NS
      + BCFM_CLK_NS - 1) / BCFM_CLK_NS;
   // Number of regenerated transitions deleted per bad doublet
   localparam logic [1:0] BCFM_DEL_TRANS = 2'h2;
   // Test sequence phases
   typedef enum logic [1:0] {
      BCFM_T_IDLE, BCFM_T_ARMED, BCFM_T_RUN, BCFM_T_WAIT
   } bcfm_test_t;
   // Stub doublet event group
   typedef struct packed {
      logic doublet;  // One valid doublet seen
      logic bad;      // Doublet failed quality check
   } bcfm_dbl_t;
endpackage

// *** logic/bcfm_top.sv ***
// Purpose: Fault management of a stub interface unit for a coupler bus
// Assumes: Stub and terminal inputs are asynchronous to I_CLK
// Notes: Registers reached over APB; analog thresholds live outside
`timescale 1ns/100ps
`default_nettype none
module bcfm_top
   import bcfm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_TRANSMIT_HOLD_FLAG_N,
   input wire logic I_BUS_QUIET,
   input wire logic I_TRANSMITTER_PERMIT_INPUT,
   input wire logic I_TX_DOUBLET,
   input wire logic I_TX_BAD,
   input wire logic I_RX_DOUBLET,
   input wire logic I_RX_BAD,
   input wire logic I_WRAP_DOUBLET,
   input wire logic I_TX_REGEN,
   input wire logic I_RX_REGEN,
   output logic O_TX_REGEN,
   output logic O_RX_REGEN,
   output logic O_POLARITY_INV,
   output logic O_TX_ENABLE,
   output logic O_COUPLER_TX_ALLOW,
   output logic [1:0] O_STATUS
);
   // Two-flop synchronisers for all asynchronous inputs
   localparam int NS = 10;
   logic [NS-1:0] sy1_ff, sy2_ff, sy3_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sy1_ff <= '0;
         sy2_ff <= '0;
         sy3_ff <= '0;
      end else begin
         sy1_ff <= {I_TRANSMIT_HOLD_FLAG_N, I_BUS_QUIET,
            I_TRANSMITTER_PERMIT_INPUT, I_TX_DOUBLET, I_TX_BAD,
            I_RX_DOUBLET, I_RX_BAD, I_WRAP_DOUBLET, I_TX_REGEN,
            I_RX_REGEN};
         sy2_ff <= sy1_ff;
         sy3_ff <= sy2_ff;
      end
   end
   logic hold, quiet, permit, tx_rg, rx_rg;
   bcfm_dbl_t txd, rxd;
   logic wrap_ev;
   assign hold = sy2_ff[9];
   assign quiet = sy2_ff[8];
   assign permit = sy2_ff[7];
   // Doublet strobes are rising edges of synchronised levels
   assign txd.doublet = sy2_ff[6] & ~sy3_ff[6];
   assign txd.bad = sy2_ff[5] & ~sy3_ff[5];
   assign rxd.doublet = sy2_ff[4] & ~sy3_ff[4];
   assign rxd.bad = sy2_ff[3] & ~sy3_ff[3];
   assign wrap_ev = sy2_ff[2] & ~sy3_ff[2];
   assign tx_rg = sy2_ff[1];
   assign rx_rg = sy2_ff[0];
   logic tx_tog, rx_tog;
   assign tx_tog = sy2_ff[1] ^ sy3_ff[1];
   assign rx_tog = sy2_ff[0] ^ sy3_ff[0];

   // Wordstring framing: hold low means transmitting
   logic hold_d_ff, in_ws_ff, end_pend_ff, ws_end;
   logic ws_start;
   assign ws_start = hold_d_ff & ~hold;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         hold_d_ff <= 1'b1;
         in_ws_ff <= 1'b0;
         end_pend_ff <= 1'b0;
      end else begin
         hold_d_ff <= hold;
         if (ws_start) begin
            in_ws_ff <= 1'b1;
         end
         // end needs hold rise then quiet
         if (!hold_d_ff || in_ws_ff) begin
            if (hold && in_ws_ff) begin
               end_pend_ff <= 1'b1;
               in_ws_ff <= 1'b0;
            end
         end
         if (ws_end) begin
            end_pend_ff <= 1'b0;
         end
      end
   end

   // Wraparound delay allowance after the end is seen
   localparam int WC_W = $clog2(BCFM_WRAP_CYC + 1);
   logic [WC_W-1:0] wrap_cnt_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wrap_cnt_ff <= '0;
      end else if (!end_pend_ff || !quiet) begin
         wrap_cnt_ff <= '0;
      end else if (wrap_cnt_ff != WC_W'(BCFM_WRAP_CYC)) begin
         wrap_cnt_ff <= wrap_cnt_ff + 1'b1;
      end
   end
   assign ws_end = end_pend_ff && quiet &&
      (wrap_cnt_ff == WC_W'(BCFM_WRAP_CYC));

   // Doublet counters for transmitted and wrapped-back doublets
   logic [CNT_W-1:0] tx_cnt_ff, wr_cnt_ff;
   logic first_inv_ff, fault_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_cnt_ff <= '0;
         wr_cnt_ff <= '0;
      end else if (ws_start) begin
         tx_cnt_ff <= '0;
         wr_cnt_ff <= '0;
      end else begin
         if (txd.doublet && !txd.bad && in_ws_ff) begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
         end
         if (wrap_ev && (!hold || end_pend_ff)) begin
            wr_cnt_ff <= wr_cnt_ff + 1'b1;
         end
      end
   end
   logic ws_bad;
   assign ws_bad = (tx_cnt_ff != wr_cnt_ff);

   // Channel select, applied only at wordstring start
   logic sel_ff, pol_ff, lock_ff;
   logic test_req, last_good_ff;
   bcfm_test_t tst_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sel_ff <= 1'b0;
      end else if (ws_end && ws_bad && !first_inv_ff) begin
         sel_ff <= ~sel_ff;
      end else if (ws_end && ws_bad && tst_ff == BCFM_T_RUN) begin
         // Spare failed the test: return to original channel
         sel_ff <= ~sel_ff;
      end else if (tst_ff == BCFM_T_ARMED && !in_ws_ff &&
                   !end_pend_ff && last_good_ff) begin
         sel_ff <= ~pol_ff;
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         pol_ff <= 1'b0;
         first_inv_ff <= 1'b0;
      end else if (ws_start) begin
         pol_ff <= sel_ff;
         first_inv_ff <= (sel_ff != pol_ff);
      end else if (ws_end) begin
         first_inv_ff <= 1'b0;
      end
   end
   assign lock_ff = first_inv_ff;

   // Channel-change error counter and coupler fault state
   logic [1:0] err_cnt_ff;
   logic change_ev;
   // no second change during switch-over wordstring
   assign change_ev = ws_end && ws_bad && !lock_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         err_cnt_ff <= '0;
      end else if (test_req && fault_ff) begin
         err_cnt_ff <= '0;
      end else if (!lock_ff) begin
         if (change_ev && err_cnt_ff != BCFM_FAULT_LIMIT) begin
            err_cnt_ff <= err_cnt_ff + 1'b1;
         end else if (ws_end && !ws_bad) begin
            err_cnt_ff <= '0;
         end
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         fault_ff <= 1'b0;
      end else if (test_req) begin
         // A request during a fault zeroes the count too, so fault stays clear
         fault_ff <= 1'b0;
      end else if (err_cnt_ff == BCFM_FAULT_LIMIT) begin
         fault_ff <= 1'b1;
      end
   end

   // Permit must be cycled low then high after a fault
   logic permit_low_ff, tx_block_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         permit_low_ff <= 1'b0;
         tx_block_ff <= 1'b0;
      end else if (fault_ff) begin
         tx_block_ff <= 1'b1;
         permit_low_ff <= 1'b0;
      end else if (tx_block_ff) begin
         if (!permit) begin
            permit_low_ff <= 1'b1;
         end else if (permit_low_ff) begin
            tx_block_ff <= 1'b0;
         end
      end
   end

   // Built-in check sequence
   logic [1:0] tstat_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         last_good_ff <= 1'b1;
      end else if (ws_end) begin
         last_good_ff <= !ws_bad;
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tst_ff <= BCFM_T_IDLE;
         tstat_ff <= BCFM_ST_NONE;
      end else if (test_req) begin
         tstat_ff <= BCFM_ST_NONE;
         tst_ff <= BCFM_T_ARMED;
      end else begin
         unique case (tst_ff)
            BCFM_T_IDLE: begin
            end
            BCFM_T_ARMED: begin
               if (!in_ws_ff && !end_pend_ff && last_good_ff) begin
                  tst_ff <= BCFM_T_WAIT;
               end
            end
            BCFM_T_WAIT: begin
               if (ws_start) begin
                  tst_ff <= BCFM_T_RUN;
               end
            end
            BCFM_T_RUN: begin
               if (ws_end) begin
                  tst_ff <= BCFM_T_IDLE;
                  tstat_ff <= ws_bad ? BCFM_ST_ONE : BCFM_ST_TWO;
               end
            end
         endcase
      end
   end

   // Deletion of regenerated transitions after bad doublets
   logic [1:0] tx_del_ff, rx_del_ff;
   logic tx_out_ff, rx_out_ff;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_del_ff <= '0;
         tx_out_ff <= 1'b0;
      end else if (txd.bad) begin
         tx_del_ff <= BCFM_DEL_TRANS;
      end else if (tx_tog && tx_del_ff != 2'h0) begin
         tx_del_ff <= tx_del_ff - 1'b1;
      end else if (tx_tog) begin
         // Only passed toggles move the output
         tx_out_ff <= tx_rg;
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_del_ff <= '0;
         rx_out_ff <= 1'b0;
      end else if (rxd.bad) begin
         rx_del_ff <= BCFM_DEL_TRANS;
      end else if (rx_tog && rx_del_ff != 2'h0) begin
         rx_del_ff <= rx_del_ff - 1'b1;
      end else if (rx_tog) begin
         rx_out_ff <= rx_rg;
      end
   end

   // APB slave, zero wait states
   logic wr_ctrl;
   assign wr_ctrl = I_PSEL && I_PENABLE && I_PWRITE &&
      (I_PADDR == BCFM_CTRL_OFS);
   assign test_req = wr_ctrl && I_PWDATA[BCFM_CTRL_TEST_BIT];
   logic [1:0] status;
   always_comb begin
      if (fault_ff) begin
         status = BCFM_ST_FAULT;
      end else if (tx_block_ff || !permit || tst_ff != BCFM_T_IDLE) begin
         status = BCFM_ST_NONE;
      end else begin
         status = tstat_ff;
      end
   end
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= '0;
      end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         unique case (I_PADDR)
            BCFM_STAT_OFS: O_PRDATA <= {28'h000_0000, pol_ff, fault_ff,
               status};
            BCFM_CNT_OFS: O_PRDATA <= {30'h0000_0000, err_cnt_ff};
            default: O_PRDATA <= '0;
         endcase
      end
   end
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE &&
      (I_PADDR != BCFM_CTRL_OFS) && (I_PADDR != BCFM_STAT_OFS) &&
      (I_PADDR != BCFM_CNT_OFS);

   // Outputs toward coupler and terminal
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_STATUS <= BCFM_ST_NONE;
         O_TX_ENABLE <= 1'b0;
         O_COUPLER_TX_ALLOW <= 1'b0;
      end else begin
         O_STATUS <= status;
         O_TX_ENABLE <= permit && !fault_ff && !tx_block_ff;
         O_COUPLER_TX_ALLOW <= permit && !fault_ff && !tx_block_ff;
      end
   end
   // coupler switches on its own after first doublet
   assign O_POLARITY_INV = pol_ff;
   assign O_TX_REGEN = tx_out_ff;
   assign O_RX_REGEN = rx_out_ff;
endmodule
`default_nettype wire

// *** tb/bcfm_chk.sv ***
// Purpose: Pin-level checker for the coupler fault manager
// Assumes: Bound into bcfm_top, one clock domain
// Notes: Latency slack covers the input synchronisers
`timescale 1ns/100ps
`default_nettype none
module bcfm_chk
   import bcfm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic I_TRANSMIT_HOLD_FLAG_N,
   input wire logic I_BUS_QUIET,
   input wire logic I_TRANSMITTER_PERMIT_INPUT,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PSLVERR,
   input wire logic O_POLARITY_INV,
   input wire logic O_TX_ENABLE,
   input wire logic O_COUPLER_TX_ALLOW,
   input wire logic [1:0] O_STATUS
);
   logic mapped;
   logic test_wr;
   logic rd_setup;
   logic is_fault;
   // Bus decode seen at the pins
   assign mapped = I_PADDR inside {BCFM_CTRL_OFS, BCFM_STAT_OFS,
      BCFM_CNT_OFS};
   assign test_wr = I_PSEL && I_PENABLE && I_PWRITE &&
      I_PADDR == BCFM_CTRL_OFS && I_PWDATA[BCFM_CTRL_TEST_BIT];
   assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
   assign is_fault = O_STATUS == BCFM_ST_FAULT;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   a_slverr_map: assert property ( // Unmapped access refused
      I_PSEL && I_PENABLE |-> O_PSLVERR == !mapped)
      else $error("slave error disagrees with decode");
   a_rdata_unmap: assert property ( // Unmapped read gives zero
      rd_setup && !mapped |=> O_PRDATA == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_stat_read: assert property (
      rd_setup && I_PADDR == BCFM_STAT_OFS |=> O_PRDATA[3:0] ==
      {$past(O_POLARITY_INV), is_fault, O_STATUS})
      else $error("status read differs from status pins");
   a_fault_txoff: assert property (
      is_fault && $past(is_fault) |-> !O_TX_ENABLE && !O_COUPLER_TX_ALLOW)
      else $error("transmitter on during fault");
   a_fault_hold: assert property (
      is_fault && !test_wr && !$past(test_wr) && !$past(test_wr, 2)
      |=> is_fault)
      else $error("fault left without test request");
   a_permit_off: assert property (
      !I_TRANSMITTER_PERMIT_INPUT [*8] |-> !O_TX_ENABLE &&
      !O_COUPLER_TX_ALLOW)
      else $error("transmit allowed without permit");
   a_permit_code: assert property (
      !I_TRANSMITTER_PERMIT_INPUT [*8] ##0 !is_fault
      |-> O_STATUS == BCFM_ST_NONE)
      else $error("status not three while permit low");
   a_pol_steady: assert property (
      $changed(O_POLARITY_INV) |-> $past(I_TRANSMIT_HOLD_FLAG_N, 4) &&
      $past(I_BUS_QUIET, 4))
      else $error("polarity changed inside a wordstring");
   c_fault: cover property ($rose(is_fault));
   c_pol: cover property ($changed(O_POLARITY_INV));
   c_two: cover property (O_STATUS == BCFM_ST_TWO);
endmodule
bind bcfm_top bcfm_chk #(.CNT_W(CNT_W)) i_chk (.I_CLK, .I_RST_N,
   .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
   .I_TRANSMIT_HOLD_FLAG_N, .I_BUS_QUIET, .I_TRANSMITTER_PERMIT_INPUT,
   .O_PRDATA, .O_PSLVERR, .O_POLARITY_INV, .O_TX_ENABLE,
   .O_COUPLER_TX_ALLOW, .O_STATUS);
`default_nettype wire

// *** tb/bcfm_partner.sv ***
// Purpose: Coupler model echoing stub doublets as wraparound
// Assumes: Doublet polarity picks the channel
// Notes: A dead channel echoes nothing
`timescale 1ns/100ps
`default_nettype none
module bcfm_partner (
   input wire logic i_clk,
   input wire logic i_tx_dbl,
   input wire logic i_hold_n,
   input wire logic i_pol,
   input wire logic [1:0] i_dead,
   output logic o_wrap,
   output logic o_quiet
);
   logic [3:0] dly_ff = '0;
   logic last_pol_ff = 1'b0;
   logic lose_ff = 1'b0;
   int idle_ff = 0;
   // channel by polarity, first doublet lost after a switch away from a dead channel
   always_ff @(posedge i_clk) begin
      dly_ff <= {dly_ff[2:0], i_tx_dbl & !i_dead[i_pol] & !lose_ff};
      if (i_pol != last_pol_ff) begin
         lose_ff <= i_dead[last_pol_ff];
         last_pol_ff <= i_pol;
      end else if ($fell(i_tx_dbl)) begin
         lose_ff <= 1'b0;
      end
   end
   assign o_wrap = dly_ff[3];
   // Bus quiet once wraparound has drained
   always_ff @(posedge i_clk) begin
      idle_ff <= (!i_hold_n || o_wrap) ? 0 : idle_ff + 1;
   end
   assign o_quiet = idle_ff > 20;
endmodule
`default_nettype wire

// *** tb/test_bus_coupler_fault_manager.sv ***
// Purpose: Self-checking bench for the coupler fault manager
// Assumes: APB slave answers with no wait states
// Notes: Partner model stands in for the coupler
`timescale 1ns/100ps
`default_nettype none
module test_bus_coupler_fault_manager;
   import bcfm_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, hold_n = 1;
   logic permit = 0, txd = 0, txb = 0, rxb = 0, txr = 0, rxr = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, rdata;
   logic [1:0] dead = '0;
   logic perr_s;
   wire logic wrap, quiet, prdy, perr, otxr, orxr, pol, txen, cen;
   wire logic [1:0] st;
   wire logic [31:0] prd;
   int errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   bcfm_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prd), .O_PREADY(prdy),
      .O_PSLVERR(perr), .I_TRANSMIT_HOLD_FLAG_N(hold_n),
      .I_BUS_QUIET(quiet), .I_TRANSMITTER_PERMIT_INPUT(permit),
      .I_TX_DOUBLET(txd), .I_TX_BAD(txb), .I_RX_DOUBLET(1'b0),
      .I_RX_BAD(rxb), .I_WRAP_DOUBLET(wrap), .I_TX_REGEN(txr),
      .I_RX_REGEN(rxr), .O_TX_REGEN(otxr), .O_RX_REGEN(orxr),
      .O_POLARITY_INV(pol), .O_TX_ENABLE(txen),
      .O_COUPLER_TX_ALLOW(cen), .O_STATUS(st));
   bcfm_partner i_cpl (.i_clk(clk), .i_tx_dbl(txd), .i_hold_n(hold_n),
      .i_pol(pol), .i_dead(dead), .o_wrap(wrap), .o_quiet(quiet));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rdata = prd;
      perr_s = perr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic wstr();
      hold_n <= 0;
      repeat (8) @(posedge clk);
      repeat (4) begin
         txd <= 1;
         repeat (3) @(posedge clk);
         txd <= 0;
         repeat (3) @(posedge clk);
      end
      repeat (10) @(posedge clk);
      hold_n <= 1;
      repeat (260) @(posedge clk);
   endtask
   task automatic cnt_is(input logic [1:0] c);
      apb(0, BCFM_CNT_OFS, '0);
      chk(rdata[1:0], c);
   endtask
   task automatic t_reset();
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata, 32'h0000_0003);
      chk(txen, 1'b0);
   endtask
   task automatic t_bad_addr();
      apb(0, 8'h0C, '0);
      chk(rdata, 32'h0000_0000);
      chk(perr_s, 1'b1);
      apb(1, BCFM_STAT_OFS, 32'hFFFF_FFFF);
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata, 32'h0000_0003);
   endtask
   task automatic t_del();
      txb <= 1;
      rxb <= 1;
      repeat (4) @(posedge clk);
      txb <= 0;
      rxb <= 0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         txr <= !txr;
         rxr <= !rxr;
         repeat (6) @(posedge clk);
         chk(otxr, i == 2);
         chk(orxr, i == 2);
      end
   endtask
   task automatic t_good();
      permit <= 1;
      repeat (8) @(posedge clk);
      chk({txen, cen}, 2'h3);
      wstr();
      cnt_is(2'h0);
      chk(pol, 1'b0);
   endtask
   task automatic t_built_in_check_mode();
      apb(1, BCFM_CTRL_OFS, 32'h0000_0001);
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata[1:0], BCFM_ST_NONE);
      wstr();
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata, 32'h0000_000A);
      chk(st, BCFM_ST_TWO);
   endtask
   task automatic t_switch();
      dead <= 2'h2;
      wstr();
      chk(pol, 1'b1);
      cnt_is(2'h1);
      wstr();
      chk(pol, 1'b0);
      cnt_is(2'h1);
      wstr();
      cnt_is(2'h0);
   endtask
   task automatic t_fault();
      dead <= 2'h3;
      for (int i = 1; i < 6; i++) begin
         wstr();
         cnt_is(2'((i + 1) / 2));
      end
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata[2:0], 3'h4);
      chk({txen, cen}, 2'h0);
      dead <= 2'h0;
      apb(1, BCFM_CTRL_OFS, 32'h0000_0001);
      repeat (4) @(posedge clk);
      cnt_is(2'h0);
      apb(0, BCFM_STAT_OFS, '0);
      chk(rdata[2:0], 3'h3);
      chk(txen, 1'b0);
      permit <= 0;
      repeat (8) @(posedge clk);
      permit <= 1;
      repeat (8) @(posedge clk);
      chk(txen, 1'b1);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence after the reset period
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      t_reset();
      t_bad_addr();
      t_del();
      t_good();
      t_built_in_check_mode();
      t_switch();
      t_fault();
      give_verdict();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
